// File: pkg/barc_defines.svh
// Timing and threshold-independent constants for the burst and restart control unit.
// Assumes a 40 MHz timebase clock; counts are derived from times in their own units.
`ifndef BARC_DEFINES_SVH
`define BARC_DEFINES_SVH

// ****************************************************************
// Clock rate
// ****************************************************************
`define BARC_CLK_HZ           40000000

// ****************************************************************
// Times as printed
// ****************************************************************
`define BARC_BLANK_MS         20
`define BARC_SPIKE_US         30
`define BARC_START_BLANK_MS   1

// ****************************************************************
// Derived cycle counts (integer division truncates; exact at 40 MHz)
// ****************************************************************
`define BARC_BLANK_CYC        ((`BARC_CLK_HZ / 1000) * `BARC_BLANK_MS)
`define BARC_SPIKE_CYC        ((`BARC_CLK_HZ / 1000000) * `BARC_SPIKE_US)
`define BARC_START_BLANK_CYC  ((`BARC_CLK_HZ / 1000) * `BARC_START_BLANK_MS)

// ****************************************************************
// Reset values
// ****************************************************************
`define BARC_RST_BIAS_ON      1'b1
`define BARC_RST_STARTUP_EN   1'b0

`endif

// File: pkg/barc_pkg.sv
// Types shared by the burst and restart control unit.
// Assumes barc_defines.svh supplies the numeric constants.
package barc_pkg;

    // Main operating states
    typedef enum logic [2:0] {
        BARC_NORMAL   = 3'b000,
        BARC_BURST    = 3'b001,
        BARC_SPIKE    = 3'b010,
        BARC_RESTART  = 3'b011,
        BARC_CHARGE   = 3'b100,
        BARC_SOFTSTRT = 3'b101
    } barc_state_type;

    // Blanking sequencer states for the extendable path
    typedef enum logic [1:0] {
        BARC_BK_IDLE  = 2'b00,
        BARC_BK_COUNT = 2'b01,
        BARC_BK_EXT   = 2'b10
    } barc_blank_type;

endpackage : barc_pkg

// File: verilog/barc_timer.sv
// Saturating cycle counter: counts while enabled, clears when not.
// Assumes synchronous enable from the control unit's own clock domain.
`timescale 1ns/1ps
`default_nettype none

module barc_timer
    import barc_pkg::*;
#(
    parameter int WIDTH = 20,
    parameter int LIMIT = 800000
)
(
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic run_in,
    output logic      done_out
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (LIMIT < 1 || LIMIT >= (1 << WIDTH))
    begin : g_bad
        $error("barc_timer: LIMIT does not fit WIDTH");
    end

    logic [WIDTH-1:0] count_r;

    // Count up while enabled, hold at limit; reset whenever run drops
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || !run_in)
            count_r <= '0;
        else if (count_r != LIMIT[WIDTH-1:0])
            count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    // Done level once the full interval has elapsed
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || !run_in)
            done_out <= 1'b0;
        else
            done_out <= (count_r == LIMIT[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) || done_out;
    end

endmodule : barc_timer

`default_nettype wire

// File: verilog/barc_sync.sv
// Single-edge pulse detector for a comparator level already synchronous to the clock.
// Assumes inputs are taken as synchronous; one register stage gives the edge.
`timescale 1ns/1ps
`default_nettype none

module barc_sync
    import barc_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic level_in,
    output logic      level_out,
    output logic      rise_out
);

    // Registered copy and rising edge of the level
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            level_out <= 1'b0;
            rise_out  <= 1'b0;
        end
        else
        begin
            level_out <= level_in;
            rise_out  <= level_in & ~level_out;
        end
    end

endmodule : barc_sync

`default_nettype wire

// File: verilog/barc_control.sv
// Burst-mode and auto-restart control unit of an off-line switching controller.
// Assumes comparator outputs and fault flags arrive synchronous to ref_clk_in.
//
// Overview of operation
// - Fixed 20 ms blanking precedes both burst entry and fault restart.
// - After 20 ms release capacitor clamp; restart gate opens at 4.0 V comparator.
// - Both restart gate inputs true, wait 30 us, then enter restart.
// - Burst uses basic blanking only; restart uses basic plus capacitor extension.
// - Counter zero normally, counts below 1.35 V, burst if still low at 20 ms.
// - Startup current source stays off throughout burst mode.
// - Burst entry sets burst flag and switches internal bias off.
// - In burst, feedback above 3.5 V restores bias and switching.
// - Burst selects the reduced 0.34 V current limit.
// - In burst, feedback down to 3.05 V switches bias off again.
// - Feedback above 4.0 V in burst leaves burst, full current limit.
// - Every listed fault leads to restart mode.
// - Only overload and open loop are blanked; other faults restart at once.
// - Restart stops switching, startup on at turn-off, off at turn-on, soft-start.
// - After soft-start recheck fault; restart again or resume normal.
// - Feedback above 4.0 V in normal starts counter, clamp released at 20 ms.
// - Soft-start re-runs at every restart attempt.
// - Capacitor node below 0.33 V requests restart, ignored in 1 ms start blank.
`timescale 1ns/1ps
`default_nettype none

`include "barc_defines.svh"

module barc_control
    import barc_pkg::*;
#(
    parameter int BLANK_CYC       = `BARC_BLANK_CYC,
    parameter int SPIKE_CYC       = `BARC_SPIKE_CYC,
    parameter int START_BLANK_CYC = `BARC_START_BLANK_CYC
)
(
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic feedback_low_comparator_in,   // Feedback below 1.35 V
    input  wire logic feedback_high_comparator_in,  // Feedback above 4.0 V
    input  wire logic burst_wake_comparator_in,     // Feedback above 3.5 V
    input  wire logic burst_sleep_comparator_in,    // Feedback at or below 3.05 V
    input  wire logic cap_node_high_comparator_in,  // Capacitor node reached 4.0 V
    input  wire logic restart_request_in,           // Capacitor node below 0.33 V
    input  wire logic supply_overvoltage_in,
    input  wire logic overtemperature_in,
    input  wire logic supply_undervoltage_in,       // Supply at turn-off level
    input  wire logic supply_turn_on_in,            // Supply reached turn-on level
    input  wire logic shorted_coupler_in,
    input  wire logic soft_start_done_in,           // Soft-start phase finished
    output logic      switching_enable_out,
    output logic      bias_on_out,
    output logic      burst_flag_out,
    output logic      reduced_limit_out,
    output logic      startup_source_on_out,
    output logic      clamp_release_switch_out,
    output logic      soft_start_run_out,
    output logic      restart_mode_out
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (BLANK_CYC < 2 || SPIKE_CYC < 2 || START_BLANK_CYC < 2)
    begin : g_bad
        $error("barc_control: interval counts too small");
    end

    // ************************************************************
    // Sampled inputs and timers
    // ************************************************************
    barc_state_type state_r;
    barc_blank_type bk_r;
    logic           fb_high_s;
    logic           fb_high_rise;
    logic           burst_done;
    logic           blank_done;
    logic           spike_done;
    logic           start_blank_done;
    logic           restart_gate;
    logic           immediate_fault;
    logic           bk_run;
    logic           spike_run;
    logic           start_blank_run;

    // Registered feedback-high level; the rise marks a load jump
    barc_sync u_fb_high (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .level_in   (feedback_high_comparator_in),
        .level_out  (fb_high_s),
        .rise_out   (fb_high_rise)
    );

    // Burst-entry blanking runs only in normal mode while feedback stays low
    barc_timer #(.WIDTH(24), .LIMIT(BLANK_CYC)) u_burst_timer (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .run_in     (state_r == BARC_NORMAL && feedback_low_comparator_in),
        .done_out   (burst_done)
    );

    // Fault blanking counts while feedback stays high; it keeps running through the
    // spike wait, otherwise the restart gate would close the moment the wait begins
    assign bk_run = (state_r == BARC_NORMAL || state_r == BARC_SPIKE) && fb_high_s;
    barc_timer #(.WIDTH(24), .LIMIT(BLANK_CYC)) u_fault_timer (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .run_in     (bk_run),
        .done_out   (blank_done)
    );

    // Restart gate needs blanking done and the capacitor node at 4.0 V
    assign restart_gate = blank_done && cap_node_high_comparator_in;
    assign spike_run    = (state_r == BARC_SPIKE) && restart_gate;
    barc_timer #(.WIDTH(12), .LIMIT(SPIKE_CYC)) u_spike_timer (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .run_in     (spike_run),
        .done_out   (spike_done)
    );

    // External request is blanked for 1 ms after each switching start
    assign start_blank_run = switching_enable_out;
    barc_timer #(.WIDTH(24), .LIMIT(START_BLANK_CYC)) u_start_blank (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .run_in     (start_blank_run),
        .done_out   (start_blank_done)
    );

    // Faults that bypass the extendable blanking
    assign immediate_fault = supply_overvoltage_in || overtemperature_in || supply_undervoltage_in
                          || shorted_coupler_in || (restart_request_in && start_blank_done);

    // ************************************************************
    // Clamp release sequencing
    // ************************************************************
    // Clamp stays closed until the fixed interval has run out
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            bk_r <= BARC_BK_IDLE;
        else
        begin
            case (bk_r)
                BARC_BK_IDLE:  bk_r <= bk_run ? BARC_BK_COUNT : BARC_BK_IDLE;
                BARC_BK_COUNT: bk_r <= !bk_run ? BARC_BK_IDLE : (blank_done ? BARC_BK_EXT : BARC_BK_COUNT);
                BARC_BK_EXT:   bk_r <= (state_r == BARC_NORMAL || state_r == BARC_SPIKE) && fb_high_s
                                       ? BARC_BK_EXT : BARC_BK_IDLE;
                default:       bk_r <= BARC_BK_IDLE;
            endcase
        end
    end

    // Clamp release switch output from a flip-flop
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            clamp_release_switch_out <= 1'b0;
        else
            clamp_release_switch_out <= blank_done && fb_high_s;
    end

    // ************************************************************
    // Main state machine
    // ************************************************************
    // Normal, burst, restart and soft-start sequencing; faults beat everything
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            state_r <= BARC_SOFTSTRT;
        else
        begin
            case (state_r)
                BARC_NORMAL:
                    if (immediate_fault)
                        state_r <= BARC_RESTART;
                    else if (blank_done)
                        state_r <= BARC_SPIKE;
                    else if (burst_done && feedback_low_comparator_in)
                        state_r <= BARC_BURST;
                BARC_BURST:
                    if (immediate_fault)
                        state_r <= BARC_RESTART;
                    else if (fb_high_rise)
                        state_r <= BARC_NORMAL;
                BARC_SPIKE:
                    if (immediate_fault)
                        state_r <= BARC_RESTART;
                    else if (!fb_high_s)
                        state_r <= BARC_NORMAL; // Overload cleared before the spike wait ran out
                    else if (spike_done)
                        state_r <= BARC_RESTART;
                BARC_RESTART:
                    if (supply_undervoltage_in)
                        state_r <= BARC_CHARGE;
                BARC_CHARGE:
                    if (supply_turn_on_in)
                        state_r <= BARC_SOFTSTRT;
                BARC_SOFTSTRT:
                    if (immediate_fault)
                        state_r <= BARC_RESTART;
                    else if (soft_start_done_in)
                        state_r <= (fb_high_s || immediate_fault) ? BARC_RESTART : BARC_NORMAL;
                default:
                    state_r <= BARC_RESTART;
            endcase
        end
    end

    // ************************************************************
    // Burst bias hysteresis
    // ************************************************************
    // Bias off on burst entry, on above 3.5 V, off again at 3.05 V
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            bias_on_out <= `BARC_RST_BIAS_ON;
        else if (state_r == BARC_NORMAL && burst_done && feedback_low_comparator_in && !immediate_fault
                 && !blank_done)
            bias_on_out <= 1'b0;
        else if (state_r == BARC_BURST)
        begin
            if (fb_high_rise || burst_wake_comparator_in)
                bias_on_out <= 1'b1;
            else if (burst_sleep_comparator_in)
                bias_on_out <= 1'b0;
        end
        else
            bias_on_out <= 1'b1;
    end

    // ************************************************************
    // Registered mode outputs
    // ************************************************************
    // Burst flag and reduced current limit follow the burst state
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            burst_flag_out    <= 1'b0;
            reduced_limit_out <= 1'b0;
        end
        else
        begin
            burst_flag_out    <= (state_r == BARC_BURST);
            reduced_limit_out <= (state_r == BARC_BURST);
        end
    end

    // Startup source only charges the supply in restart; never in burst
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            startup_source_on_out <= `BARC_RST_STARTUP_EN;
        else
            startup_source_on_out <= (state_r == BARC_CHARGE);
    end

    // Switching stops in restart and charge; in burst it follows bias
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            switching_enable_out <= 1'b0;
            soft_start_run_out   <= 1'b0;
            restart_mode_out     <= 1'b0;
        end
        else
        begin
            switching_enable_out <= (state_r == BARC_NORMAL) || (state_r == BARC_SPIKE)
                                 || (state_r == BARC_SOFTSTRT) || (state_r == BARC_BURST && bias_on_out);
            soft_start_run_out   <= (state_r == BARC_SOFTSTRT);
            restart_mode_out     <= (state_r == BARC_RESTART) || (state_r == BARC_CHARGE);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence burst_entry_s;
        state_r == BARC_NORMAL && burst_done && feedback_low_comparator_in && !immediate_fault && !blank_done;
    endsequence

    burst_entry_flag_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        burst_entry_s |=> ##1 burst_flag_out && !bias_on_out)
        else $error("burst entry did not set flag and drop bias");

    burst_limit_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (state_r == BARC_BURST) |=> reduced_limit_out)
        else $error("reduced limit not selected in burst");

    burst_startup_off_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        burst_flag_out |-> !startup_source_on_out)
        else $error("startup source on during burst");

    burst_exit_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (state_r == BARC_BURST && fb_high_rise && !immediate_fault) |=> ##1 !reduced_limit_out)
        else $error("burst not left on feedback high");

    immediate_fault_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (state_r == BARC_NORMAL && supply_overvoltage_in) |=> state_r == BARC_RESTART)
        else $error("overvoltage did not restart at once");

    spike_wait_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(restart_gate) && state_r == BARC_SPIKE |=> (state_r != BARC_RESTART || immediate_fault))
        else $error("restart entered without spike blanking");

    clamp_needs_blank_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        clamp_release_switch_out |-> $past(blank_done))
        else $error("clamp released before blanking");

    restart_quiet_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (state_r == BARC_RESTART) [*2] |-> !switching_enable_out)
        else $error("switching during restart");

endmodule : barc_control

`default_nettype wire

// File: bench/barc_far_model.sv
// Far-side model: supply rail, startup cell and soft-start timing of the power stage.
// Assumes the control unit's registered outputs and the same timebase clock.
`timescale 1ns/1ps
`default_nettype none

module barc_far_model
    import barc_pkg::*;
#(
    parameter int DROP_CYC = 8,
    parameter int CHG_CYC  = 8,
    parameter int SS_CYC   = 12
)
(
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic restart_mode_in,
    input  wire logic startup_source_on_in,
    input  wire logic soft_start_run_in,
    output logic      supply_undervoltage_out,
    output logic      supply_turn_on_out,
    output logic      soft_start_done_out
);
    // ************************************************************
    // Supply rail
    // ************************************************************
    int drop_cnt_r;
    int chg_cnt_r;
    int ss_cnt_r;

    // Rail sags only while nothing feeds it, so undervoltage is never seen in normal running
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || !restart_mode_in || startup_source_on_in)
            drop_cnt_r <= 0;
        else if (drop_cnt_r < DROP_CYC)
            drop_cnt_r <= drop_cnt_r + 1;
    end

    // Undervoltage holds until the startup cell starts charging
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || startup_source_on_in)
            supply_undervoltage_out <= 1'b0;
        else if (drop_cnt_r == DROP_CYC)
            supply_undervoltage_out <= 1'b1;
    end

    // Charging from the startup cell reaches the turn-on level after a while
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || !startup_source_on_in)
            chg_cnt_r <= 0;
        else if (chg_cnt_r < CHG_CYC)
            chg_cnt_r <= chg_cnt_r + 1;
    end
    assign supply_turn_on_out = (chg_cnt_r == CHG_CYC);

    // ************************************************************
    // Soft-start phase length
    // ************************************************************
    // Done is a level so a late sample by the control unit still sees it
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || !soft_start_run_in)
            ss_cnt_r <= 0;
        else if (ss_cnt_r < SS_CYC)
            ss_cnt_r <= ss_cnt_r + 1;
    end
    assign soft_start_done_out = (ss_cnt_r == SS_CYC);

endmodule : barc_far_model

`default_nettype wire

// File: bench/burst_and_auto_restart_control_tb_top.sv
// Self-checking bench for the burst and restart control unit.
// Assumes short blanking parameters; the far-side model supplies rail and soft-start events.
`timescale 1ns/1ps
`default_nettype none

module burst_and_auto_restart_control_tb_top;
    import barc_pkg::*;

    // ************************************************************
    // Signals
    // ************************************************************
    localparam int BLANK = 20;
    localparam int SPIKE = 6;
    localparam int SBLNK = 10;
    logic       clk;
    logic       rst_n;
    logic       fb_low, fb_high, wake, sleep, cap_high, ext_req;
    logic [2:0] flt;
    logic       uv, turn_on, ss_done;
    logic [7:0] outs;
    int         miscompares;
    int         total_checks;

    barc_control #(.BLANK_CYC(BLANK), .SPIKE_CYC(SPIKE), .START_BLANK_CYC(SBLNK)) u_barc_control (
        .ref_clk_in(clk), .rst_n_in(rst_n),
        .feedback_low_comparator_in(fb_low), .feedback_high_comparator_in(fb_high),
        .burst_wake_comparator_in(wake), .burst_sleep_comparator_in(sleep),
        .cap_node_high_comparator_in(cap_high), .restart_request_in(ext_req),
        .supply_overvoltage_in(flt[0]), .overtemperature_in(flt[1]), .shorted_coupler_in(flt[2]),
        .supply_undervoltage_in(uv), .supply_turn_on_in(turn_on), .soft_start_done_in(ss_done),
        .switching_enable_out(outs[7]), .bias_on_out(outs[6]), .burst_flag_out(outs[5]),
        .reduced_limit_out(outs[4]), .startup_source_on_out(outs[3]),
        .clamp_release_switch_out(outs[2]), .soft_start_run_out(outs[1]), .restart_mode_out(outs[0]));

    barc_far_model u_barc_far_model (
        .ref_clk_in(clk), .rst_n_in(rst_n), .restart_mode_in(outs[0]),
        .startup_source_on_in(outs[3]), .soft_start_run_in(outs[1]),
        .supply_undervoltage_out(uv), .supply_turn_on_out(turn_on), .soft_start_done_out(ss_done));

    // ************************************************************
    // Helpers
    // ************************************************************
    // 40 MHz timebase
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // Inputs move a fixed 2 ns after the edge so no race with sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    // Bounded wait on one output bit; n returns the cycles spent
    task automatic wait_for(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (outs[k] !== v && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask : wait_for

    // Let the far side run a restart cycle and come back to normal running
    task automatic recover();
        int n;
        wait_for(1, 1'b1, 80, n);
        check(outs[1], 1'b1);
        wait_for(1, 1'b0, 40, n);
        tick(3);
        check({outs[7], outs[0]}, 2'b10);
    endtask : recover

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rst_n = 1'b0;
        tick(12);
        check(outs, 8'h40);
        rst_n = 1'b1;
        recover();
    endtask : t_reset

    task automatic t_burst();
        int n;
        // A low dip shorter than the blanking window must not enter burst
        fb_low = 1'b1;
        tick(BLANK - 2);
        fb_low = 1'b0;
        tick(8);
        check(outs[5], 1'b0);
        fb_low = 1'b1;
        wait_for(5, 1'b1, BLANK + 8, n);
        check(n >= BLANK && n <= BLANK + 5, 1'b1);
        fb_low = 1'b0;
        tick(1);
        check({outs[6], outs[4], outs[3]}, 3'b010);
        check(outs[4], 1'b1);
        check(outs[3], 1'b0);
        wake = 1'b1;
        tick(3);
        check({outs[7], outs[6], outs[5]}, 3'b111);
        wake = 1'b0;
        sleep = 1'b1;
        tick(3);
        check({outs[6], outs[5], outs[3]}, 3'b010);
        sleep = 1'b0;
        fb_high = 1'b1;
        tick(4);
        fb_high = 1'b0;
        tick(2);
        check({outs[5], outs[4], outs[0]}, 3'b000);
    endtask : t_burst

    task automatic t_overload();
        int n;
        fb_high = 1'b1;
        wait_for(2, 1'b1, BLANK + 8, n);
        check(n >= BLANK && n <= BLANK + 6, 1'b1);
        tick(30);
        check(outs[0], 1'b0);
        check(outs[5], 1'b0);
        cap_high = 1'b1;
        wait_for(0, 1'b1, SPIKE + 10, n);
        check(n >= SPIKE && n <= SPIKE + 6, 1'b1);
        check(outs[7], 1'b0);
        wait_for(3, 1'b1, 40, n);
        check({outs[7], outs[3]}, 2'b01);
        wait_for(1, 1'b1, 40, n);
        check({outs[7], outs[3]}, 2'b10);
        wait_for(0, 1'b1, 30, n);
        check(outs[0], 1'b1);
        fb_high = 1'b0;
        cap_high = 1'b0;
        // Request held only inside the start-up blank must be ignored
        wait_for(1, 1'b1, 80, n);
        ext_req = 1'b1;
        tick(3);
        ext_req = 1'b0;
        tick(3);
        check(outs[0], 1'b0);
        wait_for(1, 1'b0, 40, n);
        tick(3);
        check({outs[7], outs[0]}, 2'b10);
    endtask : t_overload

    task automatic t_faults();
        int n;
        for (int k = 0; k < 4; k++)
        begin
            tick(SBLNK + 4);
            if (k < 3)
                flt[k] = 1'b1;
            else
                ext_req = 1'b1;
            wait_for(0, 1'b1, 8, n);
            check(n <= 3, 1'b1);
            check({outs[7], outs[0]}, 2'b01);
            flt = 3'h0;
            ext_req = 1'b0;
            recover();
        end
    endtask : t_faults

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // Whole run takes under 500 cycles; thirty times that means a hang
    initial
    begin
        #(25 * 15000);
        miscompares++;
        conclude();
    end

    initial
    begin
        miscompares = 0;
        total_checks = 0;
        rst_n = 1'b0;
        {fb_low, fb_high, wake, sleep, cap_high, ext_req} = 6'h00;
        flt = 3'h0;
        t_reset();
        t_burst();
        t_overload();
        t_faults();
        conclude();
    end

endmodule : burst_and_auto_restart_control_tb_top

`default_nettype wire
